// ### rtl/prpp_regs.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * read prefetch policy block.
 * Assumes a byte-addressed register port with one 32-bit word per register.
 */
`ifndef PRPP_REGS_SVH
`define PRPP_REGS_SVH

// ----------------------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------------------
`define PRPP_OFF_BRIDGE_CTRL    8'h3c
`define PRPP_OFF_PREFETCH_CTRL  8'h40
`define PRPP_OFF_STATUS         8'h50

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PRPP_MRM_LSB            4
`define PRPP_MRL_LSB            6
`define PRPP_MR_LSB             8
`define PRPP_SPECIAL_BIT        10
`define PRPP_MAXBC_LSB          12
`define PRPP_SEC_TMO_BIT        25
`define PRPP_TMO_STATUS_BIT     26

// ----------------------------------------------------------------------------
// Reset values and mode codes
// ----------------------------------------------------------------------------
`define PRPP_MRM_RST            2'h2
`define PRPP_MRL_RST            2'h0
`define PRPP_MR_RST             2'h0
`define PRPP_MAXBC_RST          3'h0
`define PRPP_PF_ONE_LINE        2'h0
`define PRPP_PF_FULL_KEEP_ONE   2'h1
`define PRPP_PF_FULL            2'h2
`define PRPP_PF_FULL_KEEP_ALL   2'h3

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PRPP_DISCARD_LONG_EXP   15
`define PRPP_DISCARD_SHORT_EXP  10
`define PRPP_DWORD_BYTES        13'h004

`endif

// ### rtl/prpp_pkg.sv
/*
 * Types shared by the read prefetch policy block.
 * Assumes everything runs on the PCI clock.
 */
`default_nettype none

package prpp_pkg;

	typedef enum logic [1:0] {cmd_mr, cmd_mrl, cmd_mrm} prpp_cmd_e;

	typedef enum logic [2:0] {st_idle, st_fetch, st_ready, st_serve, st_retain} prpp_state_e;

	typedef struct packed {
		logic        valid;
		prpp_cmd_e   cmd;
		logic [31:0] addr;
		logic [3:0]  be;
		logic        prefetchable;
	} prpp_req_s;

	typedef struct packed {
		logic        valid;
		logic        by_master;
		logic [31:0] next_addr;
	} prpp_term_s;

	typedef struct packed {
		logic        valid;
		logic        complete;
		logic        disc_first;
	} prpp_ans_s;

	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
		logic [12:0] bytes;
	} prpp_up_s;

endpackage

`default_nettype wire

// ### rtl/prpp_byte_count.sv
/*
 * Decodes the maximum read byte count code into bytes, registered.
 * Assumes the code is a static register field on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none

module prpp_byte_count
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [2:0]  code,
	output var  logic [12:0] bytes
);

	localparam logic [12:0] BC_128  = 13'h0080;
	localparam logic [12:0] BC_256  = 13'h0100;
	localparam logic [12:0] BC_512  = 13'h0200;
	localparam logic [12:0] BC_1024 = 13'h0400;
	localparam logic [12:0] BC_2048 = 13'h0800;
	localparam logic [12:0] BC_4096 = 13'h1000;

	always_ff @(posedge clk)
	begin
		if (rst)
			bytes <= BC_512;
		else
		begin
			unique case (code)
				3'h1: bytes <= BC_128;
				3'h2: bytes <= BC_256;
				3'h4: bytes <= BC_1024;
				3'h5: bytes <= BC_2048;
				3'h6: bytes <= BC_4096;
				// Unlisted codes fall back to the default size
				default: bytes <= BC_512;
			endcase
		end
	end

endmodule // prpp_byte_count

`default_nettype wire

// ### rtl/prpp_discard_timer.sv
/*
 * Discard timer: counts while run is high, one-cycle expire pulse at the end.
 * Assumes run drops for at least one cycle between separate retentions.
 */
`timescale 1ns/100ps
`default_nettype none

module prpp_discard_timer
#(
	parameter int LONG  = 32768,
	parameter int SHORT = 1024
)
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic run,
	input  wire logic short_sel,
	output var  logic expire
);

	localparam int W = $clog2(LONG) + 1;

	logic [W-1:0] cnt;
	logic [W-1:0] limit_m1;

	assign limit_m1 = short_sel ? W'(SHORT - 1) : W'(LONG - 1);

	always_ff @(posedge clk)
	begin
		if (rst || !run)
			cnt <= '0;
		else if (cnt == limit_m1)
			cnt <= '0;
		else
			cnt <= cnt + 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			expire <= 1'b0;
		else
			expire <= run && (cnt == limit_m1);
	end

endmodule // prpp_discard_timer

`default_nettype wire

// ### rtl/prpp_policy.sv
/*
 * Read prefetch policy of the PCI-to-PCIe bridge: register file, delayed
 * read tracking, upstream request sizing, retention of leftover data.
 * Assumes the PCI target front end, the upstream request engine and the
 * data buffer sit outside and all run on the PCI clock.
 */
// The placing of the registers and strobed register access are this design's own decisions.
//
// How it works
// - The read-multiple field picks one cache line (00) or full prefetch (10), reset 10.
// - Read-multiple code 01 prefetches fully and keeps leftovers when the bridge disconnects.
// - Read-multiple code 11 prefetches fully and keeps leftovers on any termination.
// - The read-line field picks one cache line (00) or full prefetch (10), reset 00.
// - Read-line code 01 prefetches fully and keeps leftovers when the master disconnects.
// - Read-line code 11 prefetches fully and keeps leftovers on any termination.
// - The plain-read field picks one line (00) or full prefetch (10), 01 reserved, reset 00.
// - Plain-read code 11 disconnects after the first doubleword.
// - With the special bit clear, a reissue with another command code gets retry.
// - With the special bit set, any memory read command completes if address and enables match.
// - The byte count field caps upstream requests whenever full prefetch is selected.
// - Byte count codes 001..110 give 128 to 4096 bytes, others 512, reset 000.
// - The discard timer runs 2^15 or 2^10 clocks, chosen by the secondary timeout bit.
//
`include "prpp_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module prpp_policy
#(
	parameter int          DISCARD_LONG  = 1 << `PRPP_DISCARD_LONG_EXP,
	parameter int          DISCARD_SHORT = 1 << `PRPP_DISCARD_SHORT_EXP,
	parameter logic [12:0] LINE_BYTES    = 13'h020
)
(
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic [7:0]           reg_addr,
	input  wire logic [31:0]          reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output var  logic [31:0]          reg_rdata,
	input  wire prpp_pkg::prpp_req_s  req,
	input  wire prpp_pkg::prpp_term_s term,
	input  wire logic                 up_done,
	output var  prpp_pkg::prpp_up_s   up,
	output var  prpp_pkg::prpp_ans_s  ans,
	output var  logic                 held
);

	// ------------------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------------------
	logic [1:0] mrm_mode;
	logic [1:0] mrl_mode;
	logic [1:0] mr_mode;
	logic       special;
	logic [2:0] maxbc_code;
	logic       sec_tmo;
	logic       tmo_status;

	logic       wr_pf;
	logic       wr_br;
	logic       expire;
	logic       discard_hit;

	prpp_pkg::prpp_state_e state;
	prpp_pkg::prpp_state_e next_state;

	assign wr_pf = reg_wr && (reg_addr == `PRPP_OFF_PREFETCH_CTRL);
	assign wr_br = reg_wr && (reg_addr == `PRPP_OFF_BRIDGE_CTRL);

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			mrm_mode   <= `PRPP_MRM_RST;
			mrl_mode   <= `PRPP_MRL_RST;
			mr_mode    <= `PRPP_MR_RST;
			special    <= 1'b0;
			maxbc_code <= `PRPP_MAXBC_RST;
		end
		else if (wr_pf)
		begin
			mrm_mode   <= reg_wdata[`PRPP_MRM_LSB +: 2];
			mrl_mode   <= reg_wdata[`PRPP_MRL_LSB +: 2];
			mr_mode    <= reg_wdata[`PRPP_MR_LSB +: 2];
			special    <= reg_wdata[`PRPP_SPECIAL_BIT];
			maxbc_code <= reg_wdata[`PRPP_MAXBC_LSB +: 3];
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			sec_tmo <= 1'b0;
		else if (wr_br)
			sec_tmo <= reg_wdata[`PRPP_SEC_TMO_BIT];
	end

	// Discarded delayed completion flag; write one clears, a new set wins
	always_ff @(posedge clk)
	begin
		if (rst)
			tmo_status <= 1'b0;
		else if (discard_hit)
			tmo_status <= 1'b1;
		else if (wr_br && reg_wdata[`PRPP_TMO_STATUS_BIT])
			tmo_status <= 1'b0;
	end

	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------
	logic [12:0] max_bytes;

	prpp_byte_count u_byte_count
	(
		.clk   (clk),
		.rst   (rst),
		.code  (maxbc_code),
		.bytes (max_bytes)
	);

	prpp_discard_timer
	#(
		.LONG  (DISCARD_LONG),
		.SHORT (DISCARD_SHORT)
	)
	u_discard_timer
	(
		.clk       (clk),
		.rst       (rst),
		.run       ((state == prpp_pkg::st_ready) || (state == prpp_pkg::st_retain)),
		.short_sel (sec_tmo),
		.expire    (expire)
	);

	assign discard_hit = expire && (state == prpp_pkg::st_ready);

	// ------------------------------------------------------------------------
	// Request decode
	// ------------------------------------------------------------------------
	logic [1:0]  req_mode;
	logic        req_full;
	logic        req_disc_first;
	logic [12:0] req_bytes;

	always_comb
	begin
		unique case (req.cmd)
			prpp_pkg::cmd_mrm: req_mode = mrm_mode;
			prpp_pkg::cmd_mrl: req_mode = mrl_mode;
			prpp_pkg::cmd_mr:  req_mode = mr_mode;
			default:           req_mode = mr_mode;
		endcase
	end

	always_comb
	begin
		if (req.cmd == prpp_pkg::cmd_mr)
			req_full = (req_mode == `PRPP_PF_FULL);
		else
			req_full = (req_mode != `PRPP_PF_ONE_LINE);
	end

	// Plain read code 11 and non-prefetchable reads stop at one doubleword
	assign req_disc_first = !req.prefetchable ||
		((req.cmd == prpp_pkg::cmd_mr) && (req_mode == `PRPP_PF_FULL_KEEP_ALL));

	always_comb
	begin
		if (req_disc_first)
			req_bytes = `PRPP_DWORD_BYTES;
		else if (req_full)
			req_bytes = max_bytes;
		else
			req_bytes = LINE_BYTES;
	end

	// ------------------------------------------------------------------------
	// Pending delayed read
	// ------------------------------------------------------------------------
	prpp_pkg::prpp_cmd_e pend_cmd;
	logic [31:0]         pend_addr;
	logic [3:0]          pend_be;
	logic [1:0]          pend_mode;
	logic                pend_pf;
	logic                pend_disc_first;
	logic [31:0]         keep_addr;
	logic                same_req;
	logic                keep_hit;
	logic                keep_on_term;
	logic                capture;

	// Address and enables must match; the command only without the special mode
	assign same_req = (req.addr == pend_addr) && (req.be == pend_be) &&
		((req.cmd == pend_cmd) || special);

	assign keep_hit = req.prefetchable && (req.addr == keep_addr);

	always_comb
	begin
		keep_on_term = 1'b0;
		if (pend_pf && !pend_disc_first)
		begin
			unique case (pend_cmd)
				prpp_pkg::cmd_mrm:
					keep_on_term = (pend_mode == `PRPP_PF_FULL_KEEP_ALL) ||
						((pend_mode == `PRPP_PF_FULL_KEEP_ONE) && !term.by_master);
				prpp_pkg::cmd_mrl:
					keep_on_term = (pend_mode == `PRPP_PF_FULL_KEEP_ALL) ||
						((pend_mode == `PRPP_PF_FULL_KEEP_ONE) && term.by_master);
				default:
					keep_on_term = 1'b0;
			endcase
		end
	end

	assign capture = req.valid &&
		((state == prpp_pkg::st_idle) || ((state == prpp_pkg::st_retain) && !keep_hit));

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pend_cmd        <= prpp_pkg::cmd_mr;
			pend_addr       <= '0;
			pend_be         <= '0;
			pend_mode       <= '0;
			pend_pf         <= 1'b0;
			pend_disc_first <= 1'b0;
		end
		else if (capture)
		begin
			pend_cmd        <= req.cmd;
			pend_addr       <= req.addr;
			pend_be         <= req.be;
			pend_mode       <= req_mode;
			pend_pf         <= req.prefetchable;
			pend_disc_first <= req_disc_first;
		end
		else if ((state == prpp_pkg::st_ready) && req.valid && same_req)
			pend_cmd        <= req.cmd;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			keep_addr <= '0;
		else if ((state == prpp_pkg::st_serve) && term.valid)
			keep_addr <= term.next_addr;
	end

	// ------------------------------------------------------------------------
	// Sequencing
	// ------------------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		unique case (state)
			prpp_pkg::st_idle:
				if (req.valid)
					next_state = prpp_pkg::st_fetch;
			prpp_pkg::st_fetch:
				if (up_done)
					next_state = prpp_pkg::st_ready;
			prpp_pkg::st_ready:
				if (expire)
					next_state = prpp_pkg::st_idle;
				else if (req.valid && same_req)
					next_state = prpp_pkg::st_serve;
			prpp_pkg::st_serve:
				if (term.valid)
					next_state = keep_on_term ? prpp_pkg::st_retain : prpp_pkg::st_idle;
			prpp_pkg::st_retain:
				if (req.valid)
					next_state = keep_hit ? prpp_pkg::st_serve : prpp_pkg::st_fetch;
				else if (expire)
					next_state = prpp_pkg::st_idle;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			state <= prpp_pkg::st_idle;
		else
			state <= next_state;
	end

	// ------------------------------------------------------------------------
	// Answers to the PCI front end
	// ------------------------------------------------------------------------
	// Requests arriving while the burst is served or fetched are retried
	always_ff @(posedge clk)
	begin
		if (rst)
			ans <= '0;
		else
		begin
			ans.valid      <= req.valid;
			ans.complete   <= req.valid &&
				(((state == prpp_pkg::st_ready) && !expire && same_req) ||
				((state == prpp_pkg::st_retain) && keep_hit));
			ans.disc_first <= req.valid && (state == prpp_pkg::st_ready) && same_req &&
				pend_disc_first;
		end
	end

	// ------------------------------------------------------------------------
	// Upstream request
	// ------------------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
			up <= '0;
		else
		begin
			up.valid <= capture;
			if (capture)
			begin
				up.addr  <= req.addr;
				up.bytes <= req_bytes;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			held <= 1'b0;
		else
			held <= (next_state == prpp_pkg::st_ready) || (next_state == prpp_pkg::st_retain);
	end

	// ------------------------------------------------------------------------
	// Register read port
	// ------------------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
			reg_rdata <= '0;
		else if (reg_rd)
		begin
			reg_rdata <= '0;
			unique case (reg_addr)
				`PRPP_OFF_PREFETCH_CTRL:
				begin
					reg_rdata[`PRPP_MRM_LSB +: 2]   <= mrm_mode;
					reg_rdata[`PRPP_MRL_LSB +: 2]   <= mrl_mode;
					reg_rdata[`PRPP_MR_LSB +: 2]    <= mr_mode;
					reg_rdata[`PRPP_SPECIAL_BIT]    <= special;
					reg_rdata[`PRPP_MAXBC_LSB +: 3] <= maxbc_code;
				end
				`PRPP_OFF_BRIDGE_CTRL:
				begin
					reg_rdata[`PRPP_SEC_TMO_BIT]    <= sec_tmo;
					reg_rdata[`PRPP_TMO_STATUS_BIT] <= tmo_status;
				end
				`PRPP_OFF_STATUS:
				begin
					reg_rdata[2:0]   <= state;
					reg_rdata[28:16] <= up.bytes;
				end
				default:
					reg_rdata <= '0;
			endcase
		end
		else
			reg_rdata <= '0;
	end

endmodule // prpp_policy

`default_nettype wire

// ### verif/prpp_policy_properties.sv
/*
 * Port-level checker of the read prefetch policy block.
 * Assumes it is bound to prpp_policy and sees only that module's ports.
 */
`timescale 1ns/100ps
`default_nettype none

module prpp_policy_properties
#(
	parameter int          DISCARD_LONG  = 40,
	parameter int          DISCARD_SHORT = 12,
	parameter logic [12:0] LINE_BYTES    = 13'h020
)
(
	input wire logic                 clk,
	input wire logic                 rst,
	input wire logic [7:0]           reg_addr,
	input wire logic [31:0]          reg_wdata,
	input wire logic                 reg_wr,
	input wire logic                 reg_rd,
	input wire logic [31:0]          reg_rdata,
	input wire prpp_pkg::prpp_req_s  req,
	input wire prpp_pkg::prpp_term_s term,
	input wire logic                 up_done,
	input wire prpp_pkg::prpp_up_s   up,
	input wire prpp_pkg::prpp_ans_s  ans,
	input wire logic                 held
);
	logic [31:0] pf;
	logic [1:0]  m;
	logic        full;
	logic        dw;
	int          hcnt;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	function automatic logic [12:0] mbc(input logic [2:0] x);
		case (x)
			3'h1: return 13'h080;
			3'h2: return 13'h100;
			3'h4: return 13'h400;
			3'h5: return 13'h800;
			3'h6: return 13'h1000;
			default: return 13'h200;
		endcase
	endfunction

	// Shadow of the prefetch control word
	always_ff @(posedge clk)
		if (rst)
			pf <= 32'h0000_0020;
		else if (reg_wr && reg_addr == 8'h40)
			pf <= reg_wdata;

	always_ff @(posedge clk)
		if (rst || !held)
			hcnt <= 0;
		else
			hcnt <= hcnt + 1;

	assign m = req.cmd == prpp_pkg::cmd_mrm ? pf[5:4] :
		req.cmd == prpp_pkg::cmd_mrl ? pf[7:6] : pf[9:8];
	assign dw = !req.prefetchable || (req.cmd == prpp_pkg::cmd_mr && m == 2'h3);
	assign full = m == 2'h2 || (req.cmd != prpp_pkg::cmd_mr && m != 2'h0);

	property p_ans;
		req.valid |=> ans.valid;
	endproperty
	a_ans: assert property (p_ans) else $error("no answer after request");
	property p_no_ans;
		!req.valid |=> !ans.valid;
	endproperty
	a_no_ans: assert property (p_no_ans) else $error("answer without request");
	property p_rdata;
		!reg_rd |=> reg_rdata == 32'h0;
	endproperty
	a_rdata: assert property (p_rdata) else $error("read data outside read slot");
	property p_dword;
		req.valid && dw ##1 up.valid |-> up.bytes == 13'h004;
	endproperty
	a_dword: assert property (p_dword) else $error("single dword fetch oversized");
	property p_full;
		req.valid && !dw && full ##1 up.valid |-> up.bytes == mbc(pf[14:12]);
	endproperty
	a_full: assert property (p_full) else $error("full prefetch size wrong");
	property p_line;
		req.valid && !dw && !full ##1 up.valid |-> up.bytes == LINE_BYTES;
	endproperty
	a_line: assert property (p_line) else $error("one line prefetch size wrong");
	property p_disc;
		req.valid && dw ##1 ans.valid && ans.complete |-> ans.disc_first;
	endproperty
	a_disc: assert property (p_disc) else $error("no disconnect after first dword");
	property p_up_cause;
		up.valid |-> $past(req.valid);
	endproperty
	a_up_cause: assert property (p_up_cause) else $error("upstream read without request");
	property p_held_rise;
		$rose(held) |-> $past(up_done) || $past(term.valid);
	endproperty
	a_held_rise: assert property (p_held_rise) else $error("no hold cause");
	property p_held_len;
		hcnt <= DISCARD_LONG + 2;
	endproperty
	a_held_len: assert property (p_held_len) else $error("held past discard time");
endmodule // prpp_policy_properties

`default_nettype wire

// ### verif/prpp_upstream_model.sv
/*
 * Upstream completer: answers the latest issued read with a done pulse.
 * Assumes up.valid is a one-cycle pulse on the PCI clock.
 */
`timescale 1ns/100ps
`default_nettype none

module prpp_upstream_model
(
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire prpp_pkg::prpp_up_s up,
	input  wire logic               slow,
	output var  logic               up_done
);
	int cnt;

	// A new issue supersedes a pending one, so its stale done is dropped
	always_ff @(posedge clk)
		if (rst)
		begin
			cnt <= 0;
			up_done <= 1'b0;
		end
		else
		begin
			up_done <= cnt == 1 && !up.valid;
			if (up.valid)
				cnt <= slow ? 25 : 2;
			else if (cnt != 0)
				cnt <= cnt - 1;
		end
endmodule // prpp_upstream_model

`default_nettype wire

// ### verif/prpp_policy_bench.sv
/*
 * Self-checking bench of the read prefetch policy block.
 * Assumes the package and design files are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin num_errors++; \
	$display("[FAIL] %s exp %h seen %h", n, e, s); end end

module prpp_policy_bench;
	logic                 clk = 1'b0;
	logic                 rst = 1'b1;
	logic [7:0]           reg_addr = 8'h0;
	logic [31:0]          reg_wdata = 32'h0;
	logic                 reg_wr = 1'b0;
	logic                 reg_rd = 1'b0;
	logic [31:0]          reg_rdata;
	prpp_pkg::prpp_req_s  req = '0;
	prpp_pkg::prpp_term_s term = '0;
	logic                 up_done;
	prpp_pkg::prpp_up_s   up;
	prpp_pkg::prpp_ans_s  ans;
	logic                 held;
	logic                 slow = 1'b0;
	int                   num_errors = 0;
	int                   checks_done = 0;
	logic [31:0]          sd = 32'h58637768;
	logic [31:0]          r;
	logic [31:0]          ad;
	logic [1:0]           cd;
	logic                 p;
	logic                 k;
	prpp_pkg::prpp_ans_s  a;
	prpp_pkg::prpp_up_s   u;
	prpp_pkg::prpp_cmd_e  cm;

	always #25 clk = ~clk;

	prpp_policy #(.DISCARD_LONG(40), .DISCARD_SHORT(12)) uut (.clk(clk), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .req(req), .term(term), .up_done(up_done), .up(up),
		.ans(ans), .held(held));
	prpp_upstream_model far (.clk(clk), .rst(rst), .up(up), .slow(slow), .up_done(up_done));

	// --------
	// Expectations
	// --------
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [12:0] xb(input int c, input logic [1:0] m, input logic [2:0] x,
		input logic pr);
		if (!pr || (c == 0 && m == 2'h3))
			return 13'h004;
		if (m == 2'h2 || (c != 0 && m != 2'h0))
			return x == 3'h1 ? 13'h080 : x == 3'h2 ? 13'h100 : x == 3'h4 ? 13'h400 :
				x == 3'h5 ? 13'h800 : x == 3'h6 ? 13'h1000 : 13'h200;
		return 13'h020;
	endfunction
	function automatic logic kp(input int c, input logic [1:0] m, input logic bm, input logic pr);
		return pr && ((c == 2 && (m == 2'h3 || (m == 2'h1 && !bm)))
			|| (c == 1 && (m == 2'h3 || (m == 2'h1 && bm))));
	endfunction

	// --------
	// Bus tasks
	// --------
	task automatic wr(input logic [7:0] ra, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= ra;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] ra);
		@(posedge clk);
		reg_addr <= ra;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		r = reg_rdata;
	endtask
	task automatic rq(input prpp_pkg::prpp_cmd_e c, input logic [31:0] ra, input logic [3:0] b,
		input logic pr);
		@(posedge clk);
		req <= '{1'b1, c, ra, b, pr};
		@(posedge clk);
		req.valid <= 1'b0;
		#1;
		a = ans;
		u = up;
	endtask
	task automatic trm(input logic bm, input logic [31:0] na);
		@(posedge clk);
		term <= '{1'b1, bm, na};
		@(posedge clk);
		term.valid <= 1'b0;
		#1;
	endtask
	task automatic wait_held;
		repeat (100)
		begin
			if (held === 1'b1)
				break;
			@(posedge clk);
			#1;
		end
		`CHK("fetched", 1'b1, held)
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// --------
	// Tests
	// --------
	initial
	begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rd(8'h40);
		`CHK("pf_reset", 32'h0000_0020, r)
		rd(8'h3c);
		`CHK("bc_reset", 32'h0, r)
		rd(8'h44);
		`CHK("unmapped", 32'h0, r)
		sd = nx(sd);
		wr(8'h40, sd);
		rd(8'h40);
		`CHK("pf_rw", sd & 32'h0000_77f0, r)
		$display("done: registers");
		wr(8'h3c, 32'h0200_0000);
		for (int n = 0; n < 2; n++)
			for (int c = 0; c < 3; c++)
				for (int m = 0; m < 5; m++)
				begin
					sd = nx(sd);
					cm = prpp_pkg::prpp_cmd_e'(c);
					cd = m[1:0];
					p = m < 4;
					ad = {sd[31:2], 2'h0};
					slow <= sd[3];
					wr(8'h40, (32'(sd[14:12]) << 12) | (32'(cd) << (8 - 2 * c)));
					rq(cm, ad, sd[7:4], p);
					`CHK("retry", 1'b0, a.complete)
					`CHK("up_bytes", xb(c, cd, sd[14:12], p), u.bytes)
					`CHK("up_addr", ad, u.addr)
					`CHK("up_valid", 1'b1, u.valid)
					wait_held;
					rq(cm, ad, sd[7:4], p);
					`CHK("complete", 1'b1, a.complete)
					`CHK("disc_first", !p || (c == 0 && cd == 2'h3), a.disc_first)
					k = kp(c, cd, n[0], p);
					trm(n[0], ad + 32'h10);
					`CHK("keep", k, held)
					if (k)
					begin
						rq(cm, ad + 32'h10, sd[7:4], 1'b1);
						`CHK("retained", 1'b1, a.complete)
						trm(1'b0, ad + 32'h20);
						repeat (30) @(posedge clk);
						#1;
						`CHK("discarded", 1'b0, held)
					end
				end
		$display("done: prefetch modes");
		slow <= 1'b0;
		for (int s = 0; s < 2; s++)
		begin
			wr(8'h40, 32'h0000_0020 | (32'(s) << 10));
			rq(prpp_pkg::cmd_mrm, 32'h1000, 4'hf, 1'b1);
			wait_held;
			rq(prpp_pkg::cmd_mr, 32'h1000, 4'hf, 1'b1);
			`CHK("cmd_change", s[0], a.complete)
			if (s == 1)
				trm(1'b1, 32'h1040);
			else
			begin
				repeat (40) @(posedge clk);
				rd(8'h3c);
				`CHK("tmo_status", 32'h0600_0000, r)
				wr(8'h3c, 32'h0600_0000);
				rd(8'h3c);
				`CHK("tmo_clear", 32'h0200_0000, r)
			end
		end
		$display("done: special mode");
		wr(8'h3c, 32'h0);
		rq(prpp_pkg::cmd_mrm, 32'h2000, 4'hf, 1'b1);
		wait_held;
		repeat (30) @(posedge clk);
		#1;
		`CHK("long_hold", 1'b1, held)
		repeat (20) @(posedge clk);
		#1;
		`CHK("long_drop", 1'b0, held)
		rd(8'h50);
		`CHK("status", 32'h0200_0000, r)
		$display("done: discard timer");
		end_of_test;
	end

	// Far above the one to one and a half thousand cycles the tests take
	initial
	begin
		#1000000;
		num_errors++;
		end_of_test;
	end
endmodule // prpp_policy_bench

bind prpp_policy prpp_policy_properties #(.DISCARD_LONG(DISCARD_LONG),
	.DISCARD_SHORT(DISCARD_SHORT), .LINE_BYTES(LINE_BYTES)) u_props (.clk(clk), .rst(rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .req(req), .term(term), .up_done(up_done), .up(up), .ans(ans),
	.held(held));

`default_nettype wire
